// file: design/dma_qlc.sv
// Event queues, queue map, priorities, linking, chaining and set/clear ports
// Behaviour
// - Four event queues, sixteen entries each
// - Any entry serves either channel type
// - Queue stores only the event number
// - Entry busy until engine accepts request
// - Map registers assign channels to queues
// - Per-queue priority toward the switch fabric
// - Final completion reloads entry from link field
// - Null link zeroes entry, keeps link
// - Chain sets event bit by completion code
// - Chain and irq enables act independently
// - One code serves final and intermediate
// - Channels may share a code differently
// - Enables change only via set/clear ports
// - Event enable via set and clear ports
// - Quick enable via quick set/clear ports
// - Irq enable via set and clear ports
// - Completion code is six bits
// - Pending clear port clears pending bits
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_qlc (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Channel events, one-cycle pulses
  input  wire logic [63:0]             dma_event,
  input  wire logic [3:0]              quick_event,
  // Completion reports from the engines
  input  wire dma_qlc_pkg::cmpl_t      cmpl,
  // Requests to the transfer engines
  output logic [3:0]                   tr_valid,
  output logic [3:0][6:0]              tr_num,
  output logic [3:0][2:0]              tr_pri,
  input  wire logic [3:0]              tr_accept,
  // Entry reload toward parameter memory
  output dma_qlc_pkg::link_t           link_req
);
  import dma_qlc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0]     qmap_reg [NQ];       // Channel queue map words
  logic [7:0]      qqmap_reg;           // Quick channel queue map
  logic [NEV-1:0]  en_reg;              // Event enables, quick on top
  logic [NCH-1:0]  ien_reg;             // Irq enables
  logic [NCH-1:0]  ipnd_reg;            // Pending irq bits
  logic [NEV-1:0]  pend_reg;            // Events awaiting admission
  logic [NEV-1:0]  busy_reg;            // Entry held by a queued request
  logic [6:0]      qent_reg [NQ][QD];   // Queue entries, head at 0
  logic [4:0]      qcnt_reg [NQ];       // Fill level per queue

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic            wr_en;               // Write takes effect this edge
  logic [31:0]     rd_word;             // Read data for the setup address
  logic            rd_err;              // Address not mapped
  logic [NEV-1:0]  en_set, en_clr;      // Enable port strobes
  logic [NCH-1:0]  ie_set, ie_clr;      // Irq enable port strobes
  logic [NCH-1:0]  ip_clr;              // Pending clear strobes

  assign wr_en = psel & penable & pready & pwrite;

  // Queue of an event number from the map registers
  function automatic logic [1:0] queue_of(input int c);
    if (c < NCH) begin
      queue_of = qmap_reg[c / CPW][MAPW * (c % CPW) +: MAPW];
    end else begin
      queue_of = qqmap_reg[MAPW * (c - NCH) +: MAPW];
    end
  endfunction

  // Read mux; set/clear ports read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr >= O_QMAP && paddr < O_QQMAP) begin
      rd_word = qmap_reg[paddr[3:2]];
    end else if (paddr == O_QQMAP) begin
      rd_word = {24'h00_0000, qqmap_reg};
    end else if (paddr >= O_QPRI && paddr < O_EEN) begin
      rd_word = {29'h0000_0000, tr_pri[2'(paddr[3:2] - 2'h1)]};
    end else if (paddr == O_EEN) begin
      rd_word = en_reg[31:0];
    end else if (paddr == O_EEN + WORD) begin
      rd_word = en_reg[63:32];
    end else if (paddr >= O_EESET && paddr < O_QEN) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == O_QEN) begin
      rd_word = {28'h000_0000, en_reg[67:64]};
    end else if (paddr == O_QESET || paddr == O_QECLR) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == O_IEN) begin
      rd_word = ien_reg[31:0];
    end else if (paddr == O_IEN + WORD) begin
      rd_word = ien_reg[63:32];
    end else if (paddr >= O_IESET && paddr < O_IPND) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == O_IPND) begin
      rd_word = ipnd_reg[31:0];
    end else if (paddr == O_IPND + WORD) begin
      rd_word = ipnd_reg[63:32];
    end else if (paddr == O_ICLR || paddr == O_ICLR + WORD) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == O_BUSY) begin
      rd_word = busy_reg[31:0];
    end else if (paddr == O_BUSY + WORD) begin
      rd_word = busy_reg[63:32];
    end else if (paddr == O_QBUSY) begin
      rd_word = {28'h000_0000, busy_reg[67:64]};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Set and clear port strobes; a 0 bit leaves the target alone
  always_comb begin
    en_set = '0;
    en_clr = '0;
    ie_set = '0;
    ie_clr = '0;
    ip_clr = '0;
    if (wr_en) begin
      if (paddr == O_EESET) en_set[31:0] = pwdata;
      else if (paddr == O_EESET + WORD) en_set[63:32] = pwdata;
      else if (paddr == O_EECLR) en_clr[31:0] = pwdata;
      else if (paddr == O_EECLR + WORD) en_clr[63:32] = pwdata;
      else if (paddr == O_QESET) en_set[67:64] = pwdata[3:0];
      else if (paddr == O_QECLR) en_clr[67:64] = pwdata[3:0];
      else if (paddr == O_IESET) ie_set[31:0] = pwdata;
      else if (paddr == O_IESET + WORD) ie_set[63:32] = pwdata;
      else if (paddr == O_IECLR) ie_clr[31:0] = pwdata;
      else if (paddr == O_IECLR + WORD) ie_clr[63:32] = pwdata;
      else if (paddr == O_ICLR) ip_clr[31:0] = pwdata;
      else if (paddr == O_ICLR + WORD) ip_clr[63:32] = pwdata;
    end
  end

  // ----------------------------------------
  // APB answer: zero wait, data taken in setup
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Map and priority registers, written directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NQ; i++) qmap_reg[i] <= 32'h0000_0000;
      qqmap_reg <= 8'h00;
      tr_pri    <= '0;
    end else if (wr_en) begin
      if (paddr >= O_QMAP && paddr < O_QQMAP) begin
        qmap_reg[paddr[3:2]] <= pwdata;
      end else if (paddr == O_QQMAP) begin
        qqmap_reg <= pwdata[7:0];
      end else if (paddr >= O_QPRI && paddr < O_EEN) begin
        tr_pri[2'(paddr[3:2] - 2'h1)] <= pwdata[2:0];
      end
    end
  end

  // Enable bits: no direct write path exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg  <= '0;
      ien_reg <= '0;
    end else begin
      en_reg  <= (en_reg & ~en_clr) | en_set;
      ien_reg <= (ien_reg & ~ie_clr) | ie_set;
    end
  end

  // ----------------------------------------
  // Completion: chaining, pending irq, link reload
  // ----------------------------------------
  logic            do_chain, do_irq;    // Selected by report kind
  logic [NEV-1:0]  chain_set;           // Chain event bit
  logic [NCH-1:0]  ip_set;              // Pending irq bit

  // Same six-bit code for both kinds; enables chosen per kind
  always_comb begin
    do_chain  = cmpl.valid & (cmpl.final_done ? cmpl.fchain : cmpl.ichain);
    do_irq    = cmpl.valid & (cmpl.final_done ? cmpl.firq : cmpl.iirq);
    chain_set = '0;
    ip_set    = '0;
    chain_set[cmpl.code] = do_chain;
    ip_set[cmpl.code]    = do_irq;
  end

  // Pending irq bits; a new completion beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipnd_reg <= '0;
    end else begin
      ipnd_reg <= (ipnd_reg & ~ip_clr) | ip_set;
    end
  end

  // Reload request after each final completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_req <= '0;
    end else begin
      link_req.valid     <= cmpl.valid & cmpl.final_done;
      link_req.null_fill <= cmpl.link == LINK_NULL;
      link_req.chan      <= cmpl.chan;
      link_req.addr      <= cmpl.link;
    end
  end

  // ----------------------------------------
  // Admission into the queues
  // ----------------------------------------
  logic [NQ-1:0]   adm_ok;              // Queue takes an event
  logic [6:0]      adm_num [NQ];        // Event number taken
  logic [NQ-1:0]   pop;                 // Head accepted by engine
  logic [NEV-1:0]  adm_vec;             // Events admitted now
  logic [NEV-1:0]  rel_vec;             // Entries released now

  assign pop = tr_valid & tr_accept;

  // Descending scan leaves the lowest candidate chosen
  always_comb begin
    adm_vec = '0;
    rel_vec = '0;
    for (int q = 0; q < NQ; q++) begin
      adm_ok[q]  = 1'b0;
      adm_num[q] = 7'h00;
      for (int c = NEV - 1; c >= 0; c--) begin
        if (pend_reg[c] && en_reg[c] && !busy_reg[c] &&
            queue_of(c) == 2'(q) && qcnt_reg[q] < 5'(QD)) begin
          adm_ok[q]  = 1'b1;
          adm_num[q] = 7'(c);
        end
      end
      if (adm_ok[q]) adm_vec[adm_num[q]] = 1'b1;
      if (pop[q]) rel_vec[qent_reg[q][0]] = 1'b1;
    end
  end

  // Pending events; a new event beats the admission clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~adm_vec) | {quick_event, dma_event} | chain_set;
    end
  end

  // Entry in use from admission until the engine accepts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= '0;
    end else begin
      busy_reg <= (busy_reg & ~rel_vec) | adm_vec;
    end
  end

  // ----------------------------------------
  // Shift queues holding event numbers only
  // ----------------------------------------
  for (genvar q = 0; q < NQ; q++) begin : g_queue
    logic [4:0] cnt_after;              // Level once the head leaves
    assign cnt_after = qcnt_reg[q] - {4'h0, pop[q]};

    // Entries shift toward the head, new one lands at the tail
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int i = 0; i < QD; i++) qent_reg[q][i] <= 7'h00;
        qcnt_reg[q] <= 5'h00;
        tr_valid[q] <= 1'b0;
      end else begin
        for (int i = 0; i < QD; i++) begin
          if (pop[q]) qent_reg[q][i] <= (i < QD - 1) ? qent_reg[q][(i + 1) % QD] : 7'h00;
          if (adm_ok[q] && cnt_after == 5'(i)) qent_reg[q][i] <= adm_num[q];
        end
        qcnt_reg[q] <= cnt_after + {4'h0, adm_ok[q]};
        tr_valid[q] <= (cnt_after + {4'h0, adm_ok[q]}) != 5'h00;
      end
    end

    // Head entry goes straight out
    assign tr_num[q] = qent_reg[q][0];
  end
endmodule // dma_qlc
`default_nettype wire

// file: include/dma_qlc_pkg.sv
// Shared constants and carrier types of the queue, link and chain controller
`default_nettype none
package dma_qlc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH   = 64;              // Ordinary channels
  localparam int NQC   = 4;               // Quick channels
  localparam int NEV   = 68;              // Event numbers in all
  localparam int NQ    = 4;               // Event queues
  localparam int QD    = 16;              // Entries per queue
  localparam int MAPW  = 2;               // Bits of one queue map field
  localparam int PRIW  = 3;               // Bits of one priority field
  localparam int CPW   = 16;              // Channels per map word
  localparam logic [15:0] LINK_NULL = 16'hFFFF;  // Link value ending a chain
  // ----------------------------------------
  // Register byte offsets (hi word of a pair at lo plus WORD)
  // ----------------------------------------
  localparam logic [11:0] WORD    = 12'h004;
  localparam logic [11:0] O_QMAP  = 12'h000;  // Channel queue map, 4 words
  localparam logic [11:0] O_QQMAP = 12'h010;  // Quick channel queue map
  localparam logic [11:0] O_QPRI  = 12'h014;  // Queue priority, 4 words
  localparam logic [11:0] O_EEN   = 12'h024;  // Event enable bits lo/hi
  localparam logic [11:0] O_EESET = 12'h02C;  // Event enable set lo/hi
  localparam logic [11:0] O_EECLR = 12'h034;  // Event enable clear lo/hi
  localparam logic [11:0] O_QEN   = 12'h03C;  // Quick event enable bits
  localparam logic [11:0] O_QESET = 12'h040;  // Quick event enable set
  localparam logic [11:0] O_QECLR = 12'h044;  // Quick event enable clear
  localparam logic [11:0] O_IEN   = 12'h048;  // Irq enable bits lo/hi
  localparam logic [11:0] O_IESET = 12'h050;  // Irq enable set lo/hi
  localparam logic [11:0] O_IECLR = 12'h058;  // Irq enable clear lo/hi
  localparam logic [11:0] O_IPND  = 12'h060;  // Pending irq bits lo/hi
  localparam logic [11:0] O_ICLR  = 12'h068;  // Pending clear lo/hi
  localparam logic [11:0] O_BUSY  = 12'h070;  // Entry in use lo/hi
  localparam logic [11:0] O_QBUSY = 12'h078;  // Quick entry in use
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;       // One-cycle completion report
    logic        final_done;  // 1 final, 0 intermediate
    logic [5:0]  code;        // Completion code
    logic        fchain;      // Final chain enable
    logic        ichain;      // Intermediate chain enable
    logic        firq;        // Final irq enable
    logic        iirq;        // Intermediate irq enable
    logic [6:0]  chan;        // Event number that completed
    logic [15:0] link;        // Link field of its entry
  } cmpl_t;
  typedef struct packed {
    logic        valid;       // One-cycle reload request
    logic        null_fill;   // Zero the entry, keep the null link
    logic [6:0]  chan;        // Event number whose entry reloads
    logic [15:0] addr;        // Link address to copy from
  } link_t;
endpackage
`default_nettype wire

// file: test/dma_qlc_asserts.sv
// Port checks of the queue, link and chain controller
`timescale 1ns/1ps
`default_nettype none
module dma_qlc_asserts (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  // Engine side
  input wire dma_qlc_pkg::cmpl_t cmpl,
  input wire logic [3:0]         tr_valid,
  input wire logic [3:0][6:0]    tr_num,
  input wire logic [3:0][2:0]    tr_pri,
  input wire logic [3:0]         tr_accept,
  input wire dma_qlc_pkg::link_t link_req
);
  import dma_qlc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  AST_IDLE_DATA: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  AST_SET_READ: assert property (psel && !penable && !pwrite && paddr == O_EESET
    |=> prdata == '0) else $error("set port read not zero");
  AST_PRI: assert property (psel && penable && pready && pwrite && paddr == O_QPRI
    |=> tr_pri[0] == $past(pwdata[2:0])) else $error("priority not written");
  AST_LINK_NULL: assert property (cmpl.valid && cmpl.final_done && cmpl.link == LINK_NULL
    |=> link_req.valid && link_req.null_fill && link_req.addr == LINK_NULL
    && link_req.chan == $past(cmpl.chan)) else $error("null link reload wrong");
  AST_LINK_COPY: assert property (cmpl.valid && cmpl.final_done && cmpl.link != LINK_NULL
    |=> link_req.valid && !link_req.null_fill && link_req.addr == $past(cmpl.link))
    else $error("link reload wrong");
  AST_LINK_CAUSE: assert property (link_req.valid |-> $past(cmpl.valid)
    && $past(cmpl.final_done)) else $error("reload without final completion");
  // Per queue head behaviour
  for (genvar q = 0; q < NQ; q++) begin : g_q
    AST_HOLD: assert property (tr_valid[q] && !tr_accept[q]
      |=> tr_valid[q] && $stable(tr_num[q])) else $error("head lost before accept");
    AST_POP: assert property (tr_valid[q] && tr_accept[q]
      |=> !(tr_valid[q] && tr_num[q] == $past(tr_num[q]))) else $error("head not popped");
    AST_NUM: assert property (tr_valid[q] |-> tr_num[q] < NEV)
      else $error("head not an event number");
  end
endmodule // dma_qlc_asserts
bind dma_qlc dma_qlc_asserts sva_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .cmpl(cmpl), .tr_valid(tr_valid), .tr_num(tr_num), .tr_pri(tr_pri),
  .tr_accept(tr_accept), .link_req(link_req));
`default_nettype wire

// file: test/te_model.sv
// Behavioural transfer engines with a per-queue stall
`timescale 1ns/1ps
`default_nettype none
module te_model (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Requests
  input  wire logic [3:0]      tr_valid,
  input  wire logic [3:0][6:0] tr_num,
  output logic      [3:0]      tr_accept,
  // Bench control
  input  wire logic [3:0]      stall
);
  import dma_qlc_pkg::*;
  logic [8:0] acc_log[$];  // Taken {queue, event number}
  // Ready level, moved only after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_accept <= '0;
    end else begin
      tr_accept <= ~stall;
    end
  end
  // Log each taken request, lower queue first
  always @(posedge pclk) begin
    for (int q = 0; q < NQ; q++) begin
      if (presetn && tr_valid[q] && tr_accept[q]) begin
        acc_log.push_back({q[1:0], tr_num[q]});
      end
    end
  end
endmodule // te_model
`default_nettype wire

// file: test/testbench.sv
// Bench for the queue, link and chain controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dma_qlc_pkg::*;
  logic            pclk = 1'b0;
  logic            presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [63:0]     dma_event;
  logic [3:0]      quick_event, tr_valid, tr_accept, stall;
  logic [3:0][6:0] tr_num;
  logic [3:0][2:0] tr_pri;
  cmpl_t           cmpl;
  link_t           link_req;
  link_t           link_seen;  // Last reload request seen
  int              error_cnt = 0;
  int              num_checks = 0;
  dma_qlc uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_event(dma_event), .quick_event(quick_event), .cmpl(cmpl), .tr_valid(tr_valid),
    .tr_num(tr_num), .tr_pri(tr_pri), .tr_accept(tr_accept), .link_req(link_req));
  te_model te (.pclk(pclk), .presetn(presetn), .tr_valid(tr_valid), .tr_num(tr_num),
    .tr_accept(tr_accept), .stall(stall));
  // Keep the last reload request for later comparison
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_seen <= '0;
    end else if (link_req.valid) begin
      link_seen <= link_req;
    end
  end
  always #12.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = {prdata[31:1], prdata[0] | (pslverr & !w)};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic fire(input logic [63:0] e, input logic [3:0] qe);
    dma_event   <= e;
    quick_event <= qe;
    @(posedge pclk);
    dma_event   <= '0;
    quick_event <= '0;
    @(posedge pclk);
  endtask
  task automatic done(input cmpl_t c);
    cmpl <= c;
    @(posedge pclk);
    cmpl <= '0;
    @(posedge pclk);
  endtask
  task automatic drain(input int n);
    while (te.acc_log.size() < n) @(posedge pclk);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dma_event, quick_event, stall} = '0;
    cmpl = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'hFFC, 32'h0000_0001);
    for (int q = 0; q < 4; q++) begin
      wr(O_QPRI + 12'(4 * q), 32'(q + 3));
      chk(32'(tr_pri[q]), 32'(q + 3));
      rdc(O_QPRI + 12'(4 * q), 32'(q + 3));
    end
    // Enable bits move only through set and clear ports
    wr(O_EEN, 32'hFFFF_FFFF);
    rdc(O_EEN, 32'h0000_0000);
    wr(O_EESET, 32'hFFFF_FFFF);
    wr(O_EESET + WORD, 32'h0000_0101);
    wr(O_EECLR + WORD, 32'h0000_0100);
    rdc(O_EEN + WORD, 32'h0000_0001);
    rdc(O_EESET, 32'h0000_0000);
    wr(O_QESET, 32'h0000_0003);
    wr(O_QECLR, 32'h0000_0001);
    rdc(O_QEN, 32'h0000_0002);
    wr(O_IESET, 32'h0000_0180);
    wr(O_IECLR, 32'h0000_0080);
    rdc(O_IEN, 32'h0000_0100);
    // Thirty-two events into a stalled queue of sixteen
    stall <= 4'h1;
    fire(64'h0000_0000_FFFF_FFFF, 4'h0);
    repeat (20) @(posedge pclk);
    rdc(O_BUSY, 32'h0000_FFFF);
    stall <= 4'h0;
    drain(32);
    for (int i = 0; i < 32; i++) chk(32'(te.acc_log[i]), 32'(i));
    te.acc_log.delete();
    // Remapped ordinary and quick channels
    wr(O_QMAP, 32'h0000_0800);
    wr(O_QQMAP, 32'h0000_000C);
    stall <= 4'hC;
    fire(64'h0000_0000_0000_0020, 4'h2);
    repeat (3) @(posedge pclk);
    chk(32'(tr_num[2]), 32'h0000_0005);
    chk(32'(tr_num[3]), 32'h0000_0041);
    chk(32'(tr_valid), 32'h0000_000C);
    rdc(O_QBUSY, 32'h0000_0002);
    stall <= 4'h0;
    drain(2);
    rdc(O_QBUSY, 32'h0000_0000);
    chk(32'(te.acc_log[1]), 32'h0000_01C1);
    te.acc_log.delete();
    // A disabled event waits for its enable
    fire(64'h0000_0100_0000_0000, 4'h0);
    repeat (6) @(posedge pclk);
    chk(32'(te.acc_log.size()), 32'h0000_0000);
    wr(O_EESET + WORD, 32'h0000_0100);
    drain(1);
    chk(32'(te.acc_log[0]), 32'h0000_0028);
    // Completion codes: chain only, irq only, shared code
    done('{1'b1, 1'b1, 6'h07, 1'b1, 1'b0, 1'b0, 1'b0, 7'h0C, 16'h0040});
    drain(2);
    chk(32'(te.acc_log[1]), 32'h0000_0007);
    chk(32'(link_seen), 32'h010C_0040);
    rdc(O_IPND, 32'h0000_0000);
    done('{1'b1, 1'b0, 6'h09, 1'b1, 1'b0, 1'b0, 1'b1, 7'h03, 16'hFFFF});
    repeat (4) @(posedge pclk);
    chk(32'(te.acc_log.size()), 32'h0000_0002);
    chk(32'(link_seen), 32'h010C_0040);
    rdc(O_IPND, 32'h0000_0200);
    done('{1'b1, 1'b1, 6'h09, 1'b1, 1'b0, 1'b0, 1'b0, 7'h14, 16'h0080});
    drain(3);
    chk(32'(te.acc_log[2]), 32'h0000_0009);
    wr(O_ICLR, 32'h0000_0001);
    rdc(O_IPND, 32'h0000_0200);
    wr(O_ICLR, 32'h0000_0200);
    rdc(O_IPND, 32'h0000_0000);
    done('{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 7'h05, 16'hFFFF});
    repeat (4) @(posedge pclk);
    chk(32'(te.acc_log.size()), 32'h0000_0003);
    chk(32'(link_seen), 32'h0185_FFFF);
    rdc(O_IPND, 32'h0000_0001);
    // Intermediate completion with only its chain enable set
    done('{1'b1, 1'b0, 6'h0A, 1'b0, 1'b1, 1'b0, 1'b0, 7'h0A, 16'h0100});
    drain(4);
    chk(32'(te.acc_log[3]), 32'h0000_000A);
    chk(32'(link_seen), 32'h0185_FFFF);
    rdc(O_IPND, 32'h0000_0001);
    final_report;
  end
endmodule // testbench
`default_nettype wire
